/* File: design/ams_params.svh */
`ifndef AMS_PARAMS_SVH
`define AMS_PARAMS_SVH

// ============================================================
// Register offsets
`define AMS_ADDR_RESULT_HIGH 8'h07
`define AMS_ADDR_RESULT_LOW 8'h08
`define AMS_ADDR_CONTROL 8'h09
`define AMS_ADDR_CHANNEL 8'h0A

// ============================================================
// Converter control field positions
`define AMS_CTRL_ENABLE_BIT 0
`define AMS_CTRL_ONE_SHOT_BIT 1
`define AMS_CTRL_SCAN_BIT 2
`define AMS_CTRL_BUF_DIS_BIT 3

// ============================================================
// Channel select and ready field positions
`define AMS_CHAN_CONV_LSB 0
`define AMS_CHAN_READ_LSB 3
`define AMS_CHAN_READY_BIT 6

// ============================================================
// Channel codes and sizes
`define AMS_CH_INPUT_CURRENT 3'h0
`define AMS_CH_INPUT_VOLTAGE 3'h1
`define AMS_CH_OUTPUT_VOLTAGE 3'h2
`define AMS_CH_OUTPUT_CURRENT 3'h3
`define AMS_CH_THERMISTOR 3'h4
`define AMS_CH_DIE_TEMP 3'h5
`define AMS_CH_EXT_INPUT 3'h6
`define AMS_NUM_CHANNELS 7
`define AMS_RESULT_WIDTH 12

// ============================================================
// Reset values
`define AMS_RESET_CONTROL 4'h0
`define AMS_RESET_CHANNEL 3'h0

`endif

/* File: design/ams_pkg.sv */
// ============================================================
// Types shared by the monitoring sequencer
package ams_pkg;

  // Sequencer states, Gray coded along idle to wait and back.
  typedef enum logic [1:0] {
    AMS_IDLE = 2'h0,
    AMS_WAIT = 2'h1
  } ams_state_t;

endpackage : ams_pkg

/* File: design/ams_sequencer.sv */
`timescale 1ns/10ps
`include "ams_params.svh"
module ams_sequencer
  import ams_pkg::*;
#(
  parameter int NUM_CH = `AMS_NUM_CHANNELS,
  parameter int RES_W = `AMS_RESULT_WIDTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register access from the serial interface engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Analog converter side
  output logic conv_start,
  output logic [2:0] conv_mux,
  output logic input_buffer_disable,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_data,
  // Interrupt to the host
  output logic interrupt_request_n
);

  // ============================================================
  // State
  typedef struct packed {
    ams_state_t state;
    logic enable;
    logic one_shot;
    logic scan;
    logic buf_dis;
    logic [2:0] convert_channel_field;
    logic [2:0] readout_channel_field;
    logic ready;
    logic irq_n;
    logic [2:0] scan_ch;
    logic [NUM_CH-1:0] seen;
    logic start;
    logic [2:0] mux;
    logic [7:0] rdata;
    logic [NUM_CH-1:0][RES_W-1:0] res;
  } ams_regs_t;

  ams_regs_t s;
  ams_regs_t next_s;
  logic [NUM_CH-1:0] capture;
  logic [RES_W-1:0] shown;
  logic wr_ctrl;
  logic wr_chan;
  logic rd_result;
  logic single_mode;
  logic poll_mode;

  // ============================================================
  // Per-channel capture strobes, one per result register.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_cap
      assign capture[gi] = (s.state == AMS_WAIT) && conv_done &&
                           (s.mux == 3'(gi));
    end
  endgenerate

  // Seven-to-one selector; an unused code shows zero.
  assign shown = (s.readout_channel_field < 3'(NUM_CH)) ?
                 s.res[s.readout_channel_field] : '0;

  assign wr_ctrl = reg_wr && (reg_addr == `AMS_ADDR_CONTROL);
  assign wr_chan = reg_wr && (reg_addr == `AMS_ADDR_CHANNEL);
  assign rd_result = reg_rd && ((reg_addr == `AMS_ADDR_RESULT_HIGH) ||
                                (reg_addr == `AMS_ADDR_RESULT_LOW));
  assign single_mode = s.one_shot && !s.scan;
  assign poll_mode = s.scan && !s.one_shot;

  // ============================================================
  // Next-state logic. Hardware events are handled last so a set
  // in the same cycle as a host clear always wins.
  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    // Register writes.
    if (wr_ctrl) begin
      next_s.enable = reg_wdata[`AMS_CTRL_ENABLE_BIT];
      next_s.one_shot = reg_wdata[`AMS_CTRL_ONE_SHOT_BIT];
      next_s.scan = reg_wdata[`AMS_CTRL_SCAN_BIT];
      next_s.buf_dis = reg_wdata[`AMS_CTRL_BUF_DIS_BIT];
      // A fresh polling run restarts the coverage tally.
      if (reg_wdata[`AMS_CTRL_ENABLE_BIT] && !s.enable &&
          reg_wdata[`AMS_CTRL_SCAN_BIT] && !reg_wdata[`AMS_CTRL_ONE_SHOT_BIT]) begin
        next_s.seen = '0;
        next_s.ready = 1'b0;
        next_s.scan_ch = `AMS_CH_INPUT_CURRENT;
      end
    end
    if (wr_chan) begin
      next_s.convert_channel_field = reg_wdata[`AMS_CHAN_CONV_LSB +: 3];
      next_s.readout_channel_field = reg_wdata[`AMS_CHAN_READ_LSB +: 3];
    end
    // Register reads.
    if (reg_rd) begin
      case (reg_addr)
        `AMS_ADDR_RESULT_HIGH: next_s.rdata = shown[RES_W-1 -: 8];
        `AMS_ADDR_RESULT_LOW: next_s.rdata = {2'h0, shown[3:0], 2'h0};
        `AMS_ADDR_CONTROL: next_s.rdata = {4'h0, s.buf_dis, s.scan, s.one_shot, s.enable};
        `AMS_ADDR_CHANNEL: next_s.rdata = {1'h0, s.ready, s.readout_channel_field,
                                           s.convert_channel_field};
        default: next_s.rdata = 8'h00;
      endcase
    end
    // Reading a single-shot result releases ready and the interrupt.
    if (rd_result && single_mode) begin
      next_s.ready = 1'b0;
      next_s.irq_n = 1'b1;
    end
    // Sequencer.
    case (s.state)
      AMS_IDLE: begin
        if (s.enable && single_mode) begin
          next_s.mux = s.convert_channel_field;
          next_s.start = 1'b1;
          next_s.state = AMS_WAIT;
        end else if (s.enable && poll_mode) begin
          next_s.mux = s.scan_ch;
          next_s.start = 1'b1;
          next_s.state = AMS_WAIT;
        end
      end
      AMS_WAIT: begin
        if (conv_done) begin
          next_s.state = AMS_IDLE;
          if (single_mode) begin
            next_s.ready = 1'b1;
            next_s.irq_n = 1'b0;
            next_s.enable = 1'b0;
          end else begin
            // Polling leaves the interrupt alone.
            next_s.seen[s.mux] = 1'b1;
            // The tally is judged after any restart in this cycle, so a fresh run
            // that coincides with a completion cannot inherit the old coverage.
            if (next_s.seen == {NUM_CH{1'b1}}) begin
              next_s.ready = 1'b1;
            end
            next_s.scan_ch = (s.mux == 3'(NUM_CH - 1)) ? 3'h0 : s.mux + 3'h1;
          end
        end
      end
      default: next_s.state = AMS_IDLE;
    endcase
    // Each finished conversion overwrites its channel's result.
    for (int i = 0; i < NUM_CH; i++) begin
      if (capture[i]) begin
        next_s.res[i] = conv_data;
      end
    end
  end

  // ============================================================
  // State register; the interrupt line idles high.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.state <= AMS_IDLE;
      s.irq_n <= 1'b1;
      s.convert_channel_field <= `AMS_RESET_CHANNEL;
      s.readout_channel_field <= `AMS_RESET_CHANNEL;
    end else begin
      s <= next_s;
    end
  end

  // ============================================================
  // Outputs, all straight from the state register.
  assign reg_rdata = s.rdata;
  assign conv_start = s.start;
  assign conv_mux = s.mux;
  assign input_buffer_disable = s.buf_dis;
  assign interrupt_request_n = s.irq_n;

  // ============================================================
  // Assertions
  sequence done_single_s;
    (s.state == AMS_WAIT) && conv_done && single_mode && !wr_ctrl;
  endsequence

  sequence kick_s;
    (s.state == AMS_IDLE) && s.enable && (single_mode || poll_mode);
  endsequence

  start_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    kick_s |=> conv_start ##1 !conv_start)
    else $error("conversion start not a single pulse");

  single_done_a: assert property (@(posedge sys_clk) disable iff (rst)
    done_single_s |=> (s.ready && !interrupt_request_n && !s.enable))
    else $error("single-shot completion flags wrong");

  irq_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!interrupt_request_n && !rd_result) |=> !interrupt_request_n)
    else $error("interrupt released without a result read");

  irq_release_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_result && single_mode && !(s.state == AMS_WAIT && conv_done)) |=>
      (interrupt_request_n && !s.ready))
    else $error("result read did not release the interrupt");

  poll_no_irq_a: assert property (@(posedge sys_clk) disable iff (rst)
    ((s.state == AMS_WAIT) && conv_done && poll_mode && interrupt_request_n) |=>
      interrupt_request_n)
    else $error("polling drove the interrupt low");

  poll_ready_a: assert property (@(posedge sys_clk) disable iff (rst)
    ($rose(s.ready) && poll_mode) |-> (s.seen == {NUM_CH{1'b1}}))
    else $error("polling ready before all channels seen");

  result_store_a: assert property (@(posedge sys_clk) disable iff (rst)
    ((s.state == AMS_WAIT) && conv_done && (s.mux < 3'(NUM_CH))) |=>
      (s.res[$past(s.mux)] == $past(conv_data)))
    else $error("result not stored for converted channel");

  result_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == `AMS_ADDR_RESULT_HIGH) |=> (reg_rdata == $past(shown[11:4])))
    else $error("high result byte wrong");

  poll_advance_a: assert property (@(posedge sys_clk) disable iff (rst)
    ((s.state == AMS_WAIT) && conv_done && poll_mode && !wr_ctrl && s.enable) |=>
      ##1 (conv_start && conv_mux == (($past(s.mux, 2) == 3'h6) ? 3'h0 :
                                      $past(s.mux, 2) + 3'h1)))
    else $error("polling did not advance to the next channel");

  poll_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
    ((s.state == AMS_IDLE) && !s.enable) |=> !conv_start)
    else $error("conversion started while disabled");

endmodule : ams_sequencer

/* File: sim/ams_conv_model.sv */
`timescale 1ns/10ps
// ============================================================
// Converter model
module ams_conv_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Converter handshake
  input wire logic conv_start,
  input wire logic [2:0] conv_mux,
  input wire logic slow,
  output logic conv_done,
  output logic [11:0] conv_data
);
  int cnt;
  logic [11:0] val;
  // One conversion at a time; the result encodes the channel so a wrong mux shows up.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      conv_done <= 1'b0;
      val <= 12'h000;
    end else begin
      conv_done <= (cnt == 1);
      if (conv_start) begin
        cnt <= slow ? 20 : 3;
        val <= {1'b1, conv_mux, 8'hA5};
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  // Outside the done pulse the data is inverted, so stale data is never mistaken for valid.
  assign conv_data = conv_done ? val : ~val;
endmodule : ams_conv_model

/* File: sim/ams_sequencer_test.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
// ============================================================
// Testbench
module ams_sequencer_test;
  logic sys_clk, rst, reg_wr, reg_rd, slow, polling;
  logic conv_start, input_buffer_disable, conv_done, interrupt_request_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [2:0] conv_mux;
  logic [11:0] conv_data;
  int failures, tests_run, nstart, n0;

  ams_sequencer DUT (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv_start(conv_start), .conv_mux(conv_mux), .input_buffer_disable(input_buffer_disable),
    .conv_done(conv_done), .conv_data(conv_data), .interrupt_request_n(interrupt_request_n));
  ams_conv_model conv (.sys_clk(sys_clk), .rst(rst), .conv_start(conv_start),
    .conv_mux(conv_mux), .slow(slow), .conv_done(conv_done), .conv_data(conv_data));

  // The clock runs at 40 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Starts are counted; in polling each must step to the next channel and the irq stays high.
  always @(posedge sys_clk) begin
    if (conv_start === 1'b1) begin
      if (polling) `CHK(conv_mux, 3'(nstart % 7))
      nstart++;
    end
    if (polling) `CHK(interrupt_request_n, 1'b1)
  end

  // ============================================================
  // Access tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data is registered, so it is taken just after the edge that samples the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic end_sim;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  // Polling the ready bit is bounded; running out counts as a mismatch.
  task automatic wait_ready;
    for (int i = 0; i < 300; i++) begin
      rd(8'h0A, d);
      if (d[6] === 1'b1) return;
    end
    failures++;
    end_sim;
  endtask : wait_ready

  // ============================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, slow, polling} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {failures, tests_run, nstart} = '0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h09, d); `CHK(d, 8'h00)
    rd(8'h0A, d); `CHK(d, 8'h00)
    rd(8'h0B, d); `CHK(d, 8'h00)
    `CHK(interrupt_request_n, 1'b1)
    // Single shots on every channel code, alternating a prompt and a slow converter.
    for (int c = 0; c < 7; c++) begin
      slow <= c[0];
      wr(8'h0A, {2'b11, 3'(c), 3'(c)});
      n0 = nstart;
      wr(8'h09, 8'h03);
      wait_ready;
      `CHK(interrupt_request_n, 1'b0)
      rd(8'h09, d); `CHK(d, 8'h02)
      `CHK(nstart, n0 + 1)
      `CHK(conv_mux, 3'(c))
      `CHK(interrupt_request_n, 1'b0)
      rd(8'h07, d); `CHK(d, {1'b1, 3'(c), 4'hA})
      @(posedge sys_clk);
      #1;
      `CHK(interrupt_request_n, 1'b1)
      rd(8'h08, d); `CHK(d, 8'h14)
      rd(8'h0A, d); `CHK(d, {2'b00, 3'(c), 3'(c)})
    end
    // Polling with a slow converter, then a stop and a check that it stays stopped.
    wr(8'h0A, 8'h00);
    slow <= 1'b1;
    nstart = 0;
    polling = 1'b1;
    wr(8'h09, 8'h05);
    rd(8'h0A, d); `CHK(d[6], 1'b0)
    wait_ready;
    `CHK(nstart >= 7, 1'b1)
    for (int c = 0; c < 7; c++) begin
      wr(8'h0A, {2'b00, 3'(c), 3'h0});
      rd(8'h07, d); `CHK(d, {1'b1, 3'(c), 4'hA})
    end
    // The unused readout code shows zero.
    wr(8'h0A, 8'h38);
    rd(8'h07, d); `CHK(d, 8'h00)
    wr(8'h09, 8'h04);
    repeat (60) @(posedge sys_clk);
    n0 = nstart;
    repeat (60) @(posedge sys_clk);
    `CHK(nstart, n0)
    rd(8'h0A, d); `CHK(d[6], 1'b1)
    // Both mode bits set is no valid mode, so enabling must start nothing.
    wr(8'h09, 8'h07);
    repeat (20) @(posedge sys_clk);
    `CHK(nstart, n0)
    rd(8'h09, d); `CHK(d, 8'h07)
    wr(8'h09, 8'h08);
    @(posedge sys_clk);
    #1;
    `CHK(input_buffer_disable, 1'b1)
    `CHK(nstart, n0)
    // A reset after the buffer-disable write must bring the control and channel registers back to zero and the irq high.
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h09, d); `CHK(d, 8'h00)
    rd(8'h0A, d); `CHK(d, 8'h00)
    `CHK(input_buffer_disable, 1'b0)
    `CHK(interrupt_request_n, 1'b1)
    end_sim;
  end
endmodule : ams_sequencer_test
